//--- verilog/gpio_cd_pkg.sv
// Constants shared by the port C / port D pin block
package gpio_cd_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_C_PIN = 8'h00;
   localparam logic [7:0] OFS_C_LAT = 8'h04;
   localparam logic [7:0] OFS_C_DIR = 8'h08;
   localparam logic [7:0] OFS_D_PIN = 8'h0C;
   localparam logic [7:0] OFS_D_LAT = 8'h10;
   localparam logic [7:0] OFS_D_DIR = 8'h14;
   localparam logic [7:0] OFS_MEMCTL = 8'h18;
   localparam logic [7:0] OFS_PSPCTL = 8'h1C;
   localparam logic [7:0] OFS_CFG = 8'h20;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int EXT_BUS_DIS_BIT = 7;
   localparam int PAR_EN_BIT = 4;
   localparam int PWM2_SEL_BIT = 0;
   localparam int SPI2_OUT_BIT = 4;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [7:0] DIR_RST = 8'hFF;
   localparam logic [7:0] LAT_RST = 8'h00;
   localparam logic [7:0] MEMCTL_RST = 8'h00;
   localparam logic [7:0] PSPCTL_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h01;
   localparam logic [31:0] RDATA_RST = 32'h00000000;

   // ----------------------------------------------------------------
   // Bus slave states
   // ----------------------------------------------------------------
   typedef enum logic {ST_ADDR, ST_DATA} bus_state_t;

endpackage

//--- verilog/bidir_port_c_d_pin_mux.sv
// Port C and port D pin multiplexer with AHB-Lite register slave
//
// Contract
// RL1: Direction bit 1 floats pin, input
// RL2: Direction bit 0 drives latch value
// RL3: Latch register reads back latched value
// RL4: Reset makes all pins inputs
// RL5: Direction reads return stored contents
// RL6: Peripherals may force pin direction
// RL7: Config bit 1 puts PWM two on C1
// RL8: Oscillator enable kills C0/C1 digital I/O; c_pin_sync[1:0] still carries the C0/C1 pin levels
// RL9: Peripheral outputs beat latch data
// RL10: PWM channel A may float on shutdown
// RL11: Sync serial drives data pin, dir 1
// RL12: Serial clock out at dir 0
// RL13: 80-pin port D needs bus disable
// RL14: Enabled bus owns port D
// RL15: Parallel port outranks all but bus and SPI two data out
// RL16: Parallel port selects TTL thresholds
// RL17: Parallel reads drive latch, writes capture
// RL18: Bus outputs outrank everything on D
// RL19: SPI two data out beats parallel
// RL20: Pin register writes latch, reads pins
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
module bidir_port_c_d_pin_mux
   import gpio_cd_pkg::*;
#(
   parameter bit EIGHTY_PIN = 1'b1
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Port C pins
   input wire logic [7:0] c_pin_in,
   output logic [7:0] c_pin_out,
   output logic [7:0] c_pin_oe,
   output logic lowpower_osc_analog_en,
   // Port D pins
   input wire logic [7:0] d_pin_in,
   output logic [7:0] d_pin_out,
   output logic [7:0] d_pin_oe,
   output logic d_ttl_sel,
   // Synchronised pin levels to peripherals
   output logic [7:0] c_pin_sync,
   output logic [7:0] d_pin_sync,
   // Timer oscillator
   input wire logic lowpower_osc_en,
   // Enhanced PWM units
   input wire logic pwm_one_en,
   input wire logic pwm_one_channel_a,
   input wire logic pwm_one_float,
   input wire logic pwm_two_en,
   input wire logic pwm_two_channel_a,
   input wire logic pwm_two_float,
   // Synchronous serial unit one
   input wire logic ssp1_sck_en,
   input wire logic ssp1_sck_out,
   input wire logic ssp1_sdo_en,
   input wire logic ssp1_sdo_out,
   input wire logic ssp1_sda_en,
   input wire logic ssp1_sda_pull_low,
   // Serial unit one
   input wire logic serial_transmit_en,
   input wire logic serial_transmit_out,
   input wire logic serial_sync_clock_en,
   input wire logic serial_sync_clock,
   input wire logic serial_sync_data_en,
   input wire logic serial_sync_data_oe,
   input wire logic serial_sync_data,
   // External memory bus
   input wire logic ext_ad_oe,
   input wire logic [7:0] ext_ad_out,
   output logic ext_bus_owns_d,
   // Parallel slave port
   input wire logic par_read_active,
   input wire logic par_write_strobe,
   output logic [7:0] par_write_data,
   output logic par_active,
   // Synchronous serial unit two
   input wire logic spi_two_en,
   input wire logic spi_two_data_out
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   bus_state_t state_r;
   logic wr_pend_r;
   logic [7:0] addr_r;
   logic addr_hi_zero_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic hresp_r;
   logic [7:0] c_lat_r;
   logic [7:0] c_dir_r;
   logic [7:0] d_lat_r;
   logic [7:0] d_dir_r;
   logic [7:0] memctl_r;
   logic [7:0] pspctl_r;
   logic [7:0] cfg_r;
   logic [7:0] c_sync1_r;
   logic [7:0] c_sync_r;
   logic [7:0] d_sync1_r;
   logic [7:0] d_sync_r;
   logic [7:0] c_out_r;
   logic [7:0] c_oe_r;
   logic [7:0] d_out_r;
   logic [7:0] d_oe_r;
   logic osc_an_r;
   logic ttl_r;
   logic bus_own_r;
   logic par_act_r;
   logic [7:0] par_wdata_r;
   logic [7:0] c_out_nxt;
   logic [7:0] c_oe_nxt;
   logic [7:0] d_out_nxt;
   logic [7:0] d_oe_nxt;
   logic [31:0] rd_nxt;
   logic take;
   logic wr_go;
   logic d_avail;
   logic par_on;
   logic [7:0] c_level;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   // One wait state keeps read data coming straight from a flop
   assign take = (state_r == ST_ADDR) && hsel && hready && htrans[1];
   assign wr_go = (state_r == ST_DATA) && wr_pend_r && addr_hi_zero_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= ST_ADDR;
         wr_pend_r <= 1'b0;
         addr_r <= 8'h00;
         addr_hi_zero_r <= 1'b0;
         hreadyout_r <= 1'b1;
         hrdata_r <= RDATA_RST;
      end else begin
         unique case (state_r)
            ST_ADDR: begin
               if (take) begin
                  state_r <= ST_DATA;
                  wr_pend_r <= hwrite;
                  addr_r <= haddr[7:0];
                  addr_hi_zero_r <= (haddr[31:8] == 24'h000000);
                  hreadyout_r <= 1'b0;
               end
            end
            ST_DATA: begin
               state_r <= ST_ADDR;
               wr_pend_r <= 1'b0;
               hreadyout_r <= 1'b1;
               hrdata_r <= wr_pend_r ? RDATA_RST : rd_nxt;
            end
         endcase
      end
   end

   // Always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp_r <= 1'b0;
      end else begin
         hresp_r <= 1'b0;
      end
   end

   // Oscillator pins read as zero while their digital input is off
   assign c_level = c_sync_r & ~{6'h00, {2{lowpower_osc_en}}}; // RL8

   always_comb begin
      rd_nxt = RDATA_RST;
      if (addr_hi_zero_r) begin
         unique case (addr_r)
            OFS_C_PIN: rd_nxt = {24'h000000, c_level}; // RL20
            OFS_C_LAT: rd_nxt = {24'h000000, c_lat_r}; // RL3
            OFS_C_DIR: rd_nxt = {24'h000000, c_dir_r}; // RL5
            OFS_D_PIN: rd_nxt = {24'h000000, d_sync_r}; // RL20
            OFS_D_LAT: rd_nxt = {24'h000000, d_lat_r}; // RL3
            OFS_D_DIR: rd_nxt = {24'h000000, d_dir_r}; // RL5
            OFS_MEMCTL: rd_nxt = {24'h000000, memctl_r};
            OFS_PSPCTL: rd_nxt = {24'h000000, pspctl_r};
            OFS_CFG: rd_nxt = {24'h000000, cfg_r};
            default: rd_nxt = RDATA_RST;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Port registers
   // ----------------------------------------------------------------
   // Pin-level and latch offsets both land in the latch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         c_lat_r <= LAT_RST;
      end else if (wr_go && (addr_r == OFS_C_PIN || addr_r == OFS_C_LAT)) begin
         c_lat_r <= hwdata[7:0]; // RL20
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         d_lat_r <= LAT_RST;
      end else if (wr_go && (addr_r == OFS_D_PIN || addr_r == OFS_D_LAT)) begin
         d_lat_r <= hwdata[7:0]; // RL20
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         c_dir_r <= DIR_RST; // RL4
      end else if (wr_go && addr_r == OFS_C_DIR) begin
         c_dir_r <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         d_dir_r <= DIR_RST; // RL4
      end else if (wr_go && addr_r == OFS_D_DIR) begin
         d_dir_r <= hwdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         memctl_r <= MEMCTL_RST;
         pspctl_r <= PSPCTL_RST;
         cfg_r <= CFG_RST;
      end else if (wr_go) begin
         if (addr_r == OFS_MEMCTL) begin
            memctl_r <= hwdata[7:0];
         end
         if (addr_r == OFS_PSPCTL) begin
            pspctl_r <= hwdata[7:0];
         end
         if (addr_r == OFS_CFG) begin
            cfg_r <= hwdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         c_sync1_r <= 8'h00;
         c_sync_r <= 8'h00;
         d_sync1_r <= 8'h00;
         d_sync_r <= 8'h00;
      end else begin
         c_sync1_r <= c_pin_in;
         c_sync_r <= c_sync1_r;
         d_sync1_r <= d_pin_in;
         d_sync_r <= d_sync1_r;
      end
   end

   // ----------------------------------------------------------------
   // Port C multiplexer
   // ----------------------------------------------------------------
   always_comb begin
      c_oe_nxt = ~c_dir_r; // RL1 RL2
      c_out_nxt = c_lat_r; // RL2
      // Compare/PWM two on bit 1 only when selected
      if (cfg_r[PWM2_SEL_BIT] && pwm_two_en && !c_dir_r[1]) begin // RL7
         c_out_nxt[1] = pwm_two_channel_a; // RL9
         c_oe_nxt[1] = ~pwm_two_float; // RL10
      end
      if (pwm_one_en && !c_dir_r[2]) begin
         c_out_nxt[2] = pwm_one_channel_a; // RL9
         c_oe_nxt[2] = ~pwm_one_float; // RL10
      end
      if (ssp1_sck_en && !c_dir_r[3]) begin
         c_out_nxt[3] = ssp1_sck_out; // RL12
      end
      // Bus data line is open drain, independent of direction
      if (ssp1_sda_en) begin
         c_out_nxt[4] = 1'b0; // RL6
         c_oe_nxt[4] = ssp1_sda_pull_low; // RL6
      end
      if (ssp1_sdo_en && !c_dir_r[5]) begin
         c_out_nxt[5] = ssp1_sdo_out; // RL9
      end
      if (serial_transmit_en && !c_dir_r[6]) begin
         c_out_nxt[6] = serial_transmit_out; // RL9
      end else if (serial_sync_clock_en && !c_dir_r[6]) begin
         c_out_nxt[6] = serial_sync_clock; // RL12
      end
      // Software leaves this direction bit at 1; the unit drives anyway
      if (serial_sync_data_en) begin
         c_out_nxt[7] = serial_sync_data; // RL11
         c_oe_nxt[7] = serial_sync_data_oe; // RL11
      end
      if (lowpower_osc_en) begin
         c_oe_nxt[1:0] = 2'b00; // RL8
      end
   end

   // ----------------------------------------------------------------
   // Port D multiplexer
   // ----------------------------------------------------------------
   assign d_avail = !EIGHTY_PIN || memctl_r[EXT_BUS_DIS_BIT]; // RL13
   assign par_on = d_avail && pspctl_r[PAR_EN_BIT]; // RL15

   always_comb begin
      d_oe_nxt = ~d_dir_r; // RL1 RL2
      d_out_nxt = d_lat_r; // RL2
      if (!d_avail) begin
         d_oe_nxt = {8{ext_ad_oe}}; // RL14 RL18
         d_out_nxt = ext_ad_out; // RL18
      end else begin
         if (par_on) begin
            d_oe_nxt = {8{par_read_active}}; // RL15 RL17
            d_out_nxt = d_lat_r; // RL17
         end
         if (spi_two_en && !d_dir_r[SPI2_OUT_BIT]) begin
            d_oe_nxt[SPI2_OUT_BIT] = 1'b1; // RL19
            d_out_nxt[SPI2_OUT_BIT] = spi_two_data_out; // RL19
         end
      end
   end

   // ----------------------------------------------------------------
   // Registered pin drive and status
   // ----------------------------------------------------------------
   // Costs a cycle of latency but keeps pin drivers glitch free
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         c_out_r <= 8'h00;
         c_oe_r <= 8'h00; // RL4
         d_out_r <= 8'h00;
         d_oe_r <= 8'h00; // RL4
      end else begin
         c_out_r <= c_out_nxt;
         c_oe_r <= c_oe_nxt;
         d_out_r <= d_out_nxt;
         d_oe_r <= d_oe_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_an_r <= 1'b0;
         ttl_r <= 1'b0;
         bus_own_r <= 1'b0;
         par_act_r <= 1'b0;
      end else begin
         osc_an_r <= lowpower_osc_en; // RL8
         ttl_r <= par_on; // RL16
         bus_own_r <= !d_avail; // RL14
         par_act_r <= par_on;
      end
   end

   // Parallel write samples the synchronised pins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         par_wdata_r <= 8'h00;
      end else if (par_on && par_write_strobe) begin
         par_wdata_r <= d_sync_r; // RL17
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign c_pin_out = c_out_r;
   assign c_pin_oe = c_oe_r;
   assign d_pin_out = d_out_r;
   assign d_pin_oe = d_oe_r;
   assign lowpower_osc_analog_en = osc_an_r;
   assign d_ttl_sel = ttl_r;
   assign ext_bus_owns_d = bus_own_r;
   assign par_active = par_act_r;
   assign par_write_data = par_wdata_r;
   assign c_pin_sync = c_sync_r;
   assign d_pin_sync = d_sync_r;

endmodule

//--- tb/gpio_cd_props.sv
// Checker of bus timing and pin overrides for the port C/D block
`timescale 1ns/100ps
module gpio_cd_props (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // Port C
   input wire logic [7:0] c_pin_oe,
   input wire logic lowpower_osc_en,
   input wire logic lowpower_osc_analog_en,
   input wire logic pwm_one_en,
   input wire logic pwm_one_float,
   // Port D
   input wire logic [7:0] d_pin_out,
   input wire logic [7:0] d_pin_oe,
   input wire logic [7:0] d_pin_sync,
   input wire logic d_ttl_sel,
   input wire logic ext_ad_oe,
   input wire logic [7:0] ext_ad_out,
   input wire logic ext_bus_owns_d,
   input wire logic par_read_active,
   input wire logic par_write_strobe,
   input wire logic [7:0] par_write_data,
   input wire logic par_active
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ----------------------------------------------------------------
   // Sequences and properties
   // ----------------------------------------------------------------
   // Four cycles of ownership, so a lagging status flag cannot misfire
   sequence s_bus;
      ext_bus_owns_d [*4];
   endsequence
   sequence s_par_rd;
      (par_active && par_read_active && !ext_bus_owns_d) [*4];
   endsequence
   sequence s_take;
      hsel && hready && htrans[1] && hreadyout;
   endsequence
   property p_wait_one;
      s_take |=> !hreadyout ##1 hreadyout;
   endproperty
   property p_okay;
      !hresp;
   endproperty
   property p_osc;
      lowpower_osc_en |=> c_pin_oe[1:0] == 2'b00 && lowpower_osc_analog_en;
   endproperty
   property p_float;
      pwm_one_en && pwm_one_float |=> !c_pin_oe[2];
   endproperty
   property p_bus;
      s_bus |-> $past(d_pin_oe) == {8{$past(ext_ad_oe, 2)}} &&
         ($past(d_pin_out) & $past(d_pin_oe)) == ($past(ext_ad_out, 2) & $past(d_pin_oe));
   endproperty
   property p_par_rd;
      s_par_rd |-> $past(d_pin_oe[3:0]) == 4'hF && $past(d_pin_oe[7:5]) == 3'h7;
   endproperty
   property p_ttl;
      d_ttl_sel == par_active;
   endproperty
   property p_cap;
      par_write_strobe && par_active |=> par_write_data == $past(d_pin_sync);
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("bus wait state not exactly one cycle");
   a_okay: assert property (p_okay)
      else $error("bus response not okay");
   a_osc: assert property (p_osc)
      else $error("oscillator pins still driven");
   a_float: assert property (p_float)
      else $error("pwm channel a driven during shutdown");
   a_bus: assert property (p_bus)
      else $error("port d not carrying memory bus");
   a_par_rd: assert property (p_par_rd)
      else $error("parallel read data not driven");
   a_ttl: assert property (p_ttl)
      else $error("input threshold select wrong");
   a_cap: assert property (p_cap)
      else $error("parallel write data not captured");
endmodule

bind bidir_port_c_d_pin_mux gpio_cd_props gpio_cd_props_inst (
   .hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout, .hresp, .c_pin_oe,
   .lowpower_osc_en, .lowpower_osc_analog_en, .pwm_one_en, .pwm_one_float, .d_pin_out,
   .d_pin_oe, .d_pin_sync, .d_ttl_sel, .ext_ad_oe, .ext_ad_out, .ext_bus_owns_d,
   .par_read_active, .par_write_strobe, .par_write_data, .par_active);

//--- tb/pin_board_model.sv
// Board model that settles each port pin from device and board drivers
`timescale 1ns/100ps
module pin_board_model (
   // Device side
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   // Board side
   input wire logic [7:0] board_drv,
   output logic [7:0] pin_lvl
);
   // Board lets go wherever the device drives, so no contention
   assign pin_lvl = (pin_out & pin_oe) | (board_drv & ~pin_oe);
endmodule

//--- tb/bidir_port_c_d_pin_mux_tb.sv
// Self-checking bench for the port C/D pin block
`timescale 1ns/100ps
module bidir_port_c_d_pin_mux_tb import gpio_cd_pkg::*; ;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, pv = 32'h0, hrdata, r;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0, par_write_strobe = 1'b0, own, pon;
   logic hreadyout, hresp, lowpower_osc_analog_en, d_ttl_sel, ext_bus_owns_d, par_active;
   logic [7:0] c_pin_in, c_pin_out, c_pin_oe, d_pin_in, d_pin_out, d_pin_oe, d_pin_sync;
   logic [7:0] par_write_data, eco, ecoe, edo, edoe, pc, pd, xc = 8'h00, xd = 8'h00;
   logic [7:0] c_pin_sync, xpw = 8'h00;
   logic [7:0] rg [0:8];
   int n_fail = 0, checks = 0, seed = 63;
   always #2 hclk = ~hclk;
   bidir_port_c_d_pin_mux bidir_port_c_d_pin_mux_inst (
      .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .c_pin_in, .c_pin_out, .c_pin_oe,
      .lowpower_osc_analog_en, .d_pin_in, .d_pin_out, .d_pin_oe, .d_ttl_sel, .c_pin_sync,
      .d_pin_sync, .lowpower_osc_en(pv[0]), .pwm_one_en(pv[1]), .pwm_one_channel_a(pv[2]),
      .pwm_one_float(pv[3]), .pwm_two_en(pv[4]), .pwm_two_channel_a(pv[5]),
      .pwm_two_float(pv[6]), .ssp1_sck_en(pv[7]), .ssp1_sck_out(pv[8]), .ssp1_sdo_en(pv[9]),
      .ssp1_sdo_out(pv[10]), .ssp1_sda_en(pv[11]), .ssp1_sda_pull_low(pv[12]),
      .serial_transmit_en(pv[13]), .serial_transmit_out(pv[14]),
      .serial_sync_clock_en(pv[15]), .serial_sync_clock(pv[16]),
      .serial_sync_data_en(pv[17]), .serial_sync_data_oe(pv[18]), .serial_sync_data(pv[19]),
      .ext_ad_oe(pv[20]), .ext_ad_out(pv[31:24]), .ext_bus_owns_d, .par_read_active(pv[21]),
      .par_write_strobe, .par_write_data, .par_active, .spi_two_en(pv[22]),
      .spi_two_data_out(pv[23]));
   pin_board_model board_c (.pin_out(c_pin_out), .pin_oe(c_pin_oe), .board_drv(xc),
      .pin_lvl(c_pin_in));
   pin_board_model board_d (.pin_out(d_pin_out), .pin_oe(d_pin_oe), .board_drv(xd),
      .pin_lvl(d_pin_in));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
      output logic [31:0] rd);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic wreg(input int i, input logic [31:0] d);
      logic [31:0] t;
      bus(8'(i * 4), 1'b1, d, t);
      if (i == 0 || i == 3) rg[i + 1] = d[7:0];
      else if (i < 9) rg[i] = d[7:0];
   endtask
   task automatic model;
      eco = rg[1];
      ecoe = ~rg[2];
      if (pv[1] && !rg[2][2]) {ecoe[2], eco[2]} = {!pv[3], pv[2]};
      if (pv[4] && rg[8][0] && !rg[2][1]) {ecoe[1], eco[1]} = {!pv[6], pv[5]};
      if (pv[7] && !rg[2][3]) eco[3] = pv[8];
      if (pv[9] && !rg[2][5]) eco[5] = pv[10];
      if (pv[11]) {ecoe[4], eco[4]} = {pv[12], 1'b0};
      if (pv[13] && !rg[2][6]) eco[6] = pv[14];
      else if (pv[15] && !rg[2][6]) eco[6] = pv[16];
      if (pv[17]) {ecoe[7], eco[7]} = {pv[18], pv[19]};
      if (pv[0]) ecoe[1:0] = 2'b00;
      own = !rg[6][7];
      pon = rg[7][4] && !own;
      edo = rg[4];
      edoe = ~rg[5];
      if (pon) edoe = {8{pv[21]}};
      if (pv[22] && !rg[5][4]) {edoe[4], edo[4]} = {1'b1, pv[23]};
      if (own) {edoe, edo} = {{8{pv[20]}}, pv[31:24]};
      eco = eco & ecoe;
      edo = edo & edoe;
      pc = eco | (xc & ~ecoe);
      pd = edo | (xd & ~edoe);
   endtask
   task automatic cmp_pins;
      chk("c_pin_oe", c_pin_oe, ecoe);
      chk("c_pin_sync", c_pin_sync, pc);
      chk("c_pin_out", c_pin_out & c_pin_oe, eco);
      chk("d_pin_oe", d_pin_oe, edoe);
      chk("d_pin_out", d_pin_out & d_pin_oe, edo);
      chk("d_pin_sync", d_pin_sync, pd);
      chk("status", {ext_bus_owns_d, par_active, d_ttl_sel, lowpower_osc_analog_en},
         {own, pon, pon, pv[0]});
   endtask
   task automatic rd_all;
      logic [31:0] t;
      logic [7:0] e;
      for (int i = 0; i < 10; i++) begin
         bus(8'(i * 4), 1'b0, 32'h0, t);
         e = i == 0 ? pc & ~{6'h00, {2{pv[0]}}} : i == 3 ? pd : i < 9 ? rg[i] : 8'h00;
         chk("read data", t, {24'h0, e});
      end
   endtask
   task automatic init_model;
      for (int i = 0; i < 9; i++) rg[i] = (i == 2 || i == 5) ? 8'hFF : {7'h00, i == 8};
      xpw = 8'h00;
   endtask
   task automatic print_verdict;
      if (n_fail == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      init_model;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      model;
      cmp_pins;
      rd_all;
      repeat (80) begin
         r = $random(seed);
         wreg(int'(r[7:0]) % 10, $random(seed));
         r = $random(seed);
         r[17] = r[17] & rg[2][7];
         pv <= r;
         {xd, xc} <= 16'($random(seed));
         repeat (4) @(posedge hclk);
         model;
         cmp_pins;
         par_write_strobe <= 1'b1;
         @(posedge hclk);
         par_write_strobe <= 1'b0;
         rd_all;
         if (pon) xpw = pd;
         chk("par_write_data", par_write_data, xpw);
      end
      // Second reset mid-run must undo every register write
      hresetn <= 1'b0;
      pv <= 32'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      init_model;
      repeat (4) @(posedge hclk);
      model;
      cmp_pins;
      rd_all;
      chk("par_write_data", par_write_data, xpw);
      print_verdict;
   end
   // Hang guard well beyond the expected run length
   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      print_verdict;
   end
endmodule
